// File: verilog/ass_defs.vh
/*
 * Constants of the analog scan sequencer: scan-table layout, sizes and
 * stream timing.
 * Assumes inclusion by bare name from the sequencer design files.
 */
`ifndef ASS_DEFS_VH
`define ASS_DEFS_VH

`define ASS_TABLE_DEPTH 2048
`define ASS_ADDR_W 11
`define ASS_ENTRY_W 16
`define ASS_SAMPLE_W 16
`define ASS_EOL_BIT 15
`define ASS_BUSSEL_HI 1
`define ASS_BUSSEL_LO 0
`define ASS_FIFO_DEPTH 4
`define ASS_FIFO_AW 2
// Clock period and stream rate ceiling (bytes per word is 2)
`define ASS_CLK_PERIOD_NS 4
`define ASS_STREAM_MBPS 10
`define ASS_BYTES_PER_WORD 2
// Least ns between words: 2 bytes / 10 MB/s = 200 ns
`define ASS_WORD_GAP_NS ((`ASS_BYTES_PER_WORD * 1000) / `ASS_STREAM_MBPS)
// Least cycles between words, rounded up
`define ASS_WORD_GAP_CYC ((`ASS_WORD_GAP_NS + `ASS_CLK_PERIOD_NS - 1) / `ASS_CLK_PERIOD_NS)
`define ASS_GAP_W 8

`endif

// File: verilog/ass_fifo.v
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none

module ass_fifo #(
    parameter WIDTH = 18,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // Clock and reset
    input wire clock_i,
    input wire rst_i,
    // Fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // Drain side
    output reg out_valid_o,
    input wire out_ready_i,
    output reg [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready_o = (count != DEPTH[AW:0]);
    assign push = in_valid_i && in_ready_o;
    // Output register reloads when empty or being taken
    assign pop = (count != {(AW+1){1'b0}}) &&
                 (!out_valid_o || out_ready_i);

    always @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            out_valid_o <= 1'b0;
            out_data_o <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
                out_data_o <= mem[rd_ptr];
                out_valid_o <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
            case ({push, pop})
                2'b10: count <= count + 1'b1;
                2'b01: count <= count - 1'b1;
                default: count <= count;
            endcase
        end
    end
endmodule

`default_nettype wire

// File: verilog/ass_sequencer.v
/*
 * Analog scan sequencer: steps the scan table, drives frame-start and
 * channel-step to conditioning modules, and sources the digital stream.
 * Assumes the converter delivers one result per conv_done_i pulse, a
 * sample tick on sample_tick_i, and a table loaded before run_i rises.
 */
// Contract
// - Device drives frame-start and channel-step to all conditioning modules.
// - Four analog channels A..D are used in rotating four-phase order.
// - Device and conditioning modules each hold a scan-order table.
// - Entry low two bits cycle A,B,C,D; other order is free.
// - Scan sequences hold up to 2048 entries per frame.
// - One digitized sample goes onto the stream per sample tick.
// - Device originates stream data and timing; sinks follow it.
// - Stream allows several sinks and extra sources inserting words.
// - Stream traffic stays at or below 10 megabytes per second.
// - Only end-of-list bit 15 and bus-select bits 1..0 are used.
// - Address advances per conversion; selects entry and output slot.
// - Device drives a stream frame signal marking the scan period.
`timescale 1ns/100ps
`default_nettype none
`include "ass_defs.vh"

module ass_sequencer (
    // Clock and reset
    input wire clock_i,
    input wire rst_i,
    // Control
    input wire run_i,
    input wire sample_tick_i,
    // Scan-table load port
    input wire tbl_we_i,
    input wire [`ASS_ADDR_W-1:0] tbl_waddr_i,
    input wire [`ASS_ENTRY_W-1:0] tbl_wdata_i,
    // Converter
    input wire conv_done_i,
    input wire [`ASS_SAMPLE_W-1:0] conv_data_i,
    output reg conv_start_o,
    output reg [1:0] bus_select_o,
    // Conditioning module control
    output reg frame_start_o,
    output reg channel_step_o,
    // Digital stream bus
    output reg stream_valid_o,
    output reg [`ASS_SAMPLE_W-1:0] stream_data_o,
    output reg [`ASS_ADDR_W-1:0] stream_addr_o,
    output reg stream_frame_o,
    output reg stream_src_o,
    input wire ext_valid_i,
    input wire [`ASS_SAMPLE_W-1:0] ext_data_i,
    // Status
    output reg [`ASS_ADDR_W-1:0] scan_addr_o,
    output reg sequence_error_o,
    output reg overrun_o
);
    localparam FW = `ASS_SAMPLE_W + `ASS_ADDR_W + 1;
    localparam ST_IDLE = 3'b001;
    localparam ST_CONV = 3'b010;
    localparam ST_WAIT = 3'b100;
    // Reload value of the word-spacing counter
    localparam integer GAP_LAST = `ASS_WORD_GAP_CYC - 1;

    reg [`ASS_ENTRY_W-1:0] table_mem [0:`ASS_TABLE_DEPTH-1];
    reg [2:0] state;
    reg [`ASS_ADDR_W-1:0] scan_addr;
    reg [1:0] cur_sel;
    reg cur_eol;
    reg [1:0] prev_sel;
    reg prev_ok;
    reg [`ASS_GAP_W-1:0] gap_cnt;
    wire [`ASS_ENTRY_W-1:0] entry;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [FW-1:0] fifo_out_data;
    wire gap_done;
    wire stream_take;

    always @(posedge clock_i) begin
        if (tbl_we_i) begin
            table_mem[tbl_waddr_i] <= tbl_wdata_i;
        end
    end
    // Entry is read at once so a tick can use it in its own cycle
    assign entry = table_mem[scan_addr];

    assign gap_done = (gap_cnt == {`ASS_GAP_W{1'b0}});
    assign stream_take = fifo_out_valid && gap_done && !ext_valid_i;

    ass_fifo #(
        .WIDTH(FW),
        .DEPTH(`ASS_FIFO_DEPTH),
        .AW(`ASS_FIFO_AW)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .in_valid_i(state == ST_WAIT && conv_done_i),
        .in_ready_o(fifo_in_ready),
        .in_data_i({cur_eol, scan_addr, conv_data_i}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(stream_take),
        .out_data_o(fifo_out_data)
    );

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            scan_addr <= {`ASS_ADDR_W{1'b0}};
            cur_sel <= 2'h0;
            cur_eol <= 1'b0;
            prev_sel <= 2'h3;
            prev_ok <= 1'b0;
            conv_start_o <= 1'b0;
            bus_select_o <= 2'h0;
            frame_start_o <= 1'b0;
            channel_step_o <= 1'b0;
            scan_addr_o <= {`ASS_ADDR_W{1'b0}};
            sequence_error_o <= 1'b0;
            overrun_o <= 1'b0;
        end else begin
            conv_start_o <= 1'b0;
            frame_start_o <= 1'b0;
            channel_step_o <= 1'b0;
            scan_addr_o <= scan_addr;
            case (state)
                ST_IDLE: begin
                    if (run_i && sample_tick_i) begin
                        // only bit 15 and bits 1..0 used
                        cur_sel <= entry[`ASS_BUSSEL_HI:`ASS_BUSSEL_LO];
                        cur_eol <= entry[`ASS_EOL_BIT];
                        bus_select_o <= entry[`ASS_BUSSEL_HI:`ASS_BUSSEL_LO];
                        // low bits follow previous
                        // Skipped on the first entry after reset or end of list
                        if (prev_ok && entry[1:0] != prev_sel + 2'h1) begin
                            sequence_error_o <= 1'b1;
                        end
                        if (scan_addr == {`ASS_ADDR_W{1'b0}}) begin
                            frame_start_o <= 1'b1;
                        end
                        conv_start_o <= 1'b1;
                        state <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (conv_done_i) begin
                        // A full buffer drops the word and flags it
                        if (!fifo_in_ready) begin
                            overrun_o <= 1'b1;
                        end
                        prev_sel <= cur_sel;
                        prev_ok <= !cur_eol;
                        channel_step_o <= 1'b1;
                        if (cur_eol) begin
                            scan_addr <= {`ASS_ADDR_W{1'b0}};
                        end else begin
                            scan_addr <= scan_addr + 1'b1;
                        end
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // stream data and timing sourced here
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            stream_valid_o <= 1'b0;
            stream_data_o <= {`ASS_SAMPLE_W{1'b0}};
            stream_addr_o <= {`ASS_ADDR_W{1'b0}};
            stream_frame_o <= 1'b0;
            stream_src_o <= 1'b0;
            gap_cnt <= {`ASS_GAP_W{1'b0}};
        end else begin
            stream_valid_o <= 1'b0;
            if (!gap_done) begin
                gap_cnt <= gap_cnt - 1'b1;
            end
            // External words share the spacing and win the slot
            if (gap_done && ext_valid_i) begin
                stream_valid_o <= 1'b1;
                stream_data_o <= ext_data_i;
                stream_src_o <= 1'b1;
                gap_cnt <= GAP_LAST[`ASS_GAP_W-1:0];
            end else if (stream_take) begin
                stream_valid_o <= 1'b1;
                stream_data_o <= fifo_out_data[`ASS_SAMPLE_W-1:0];
                stream_addr_o <= fifo_out_data[FW-2:`ASS_SAMPLE_W];
                stream_src_o <= 1'b0;
                // high through the scan, low on the last entry's word
                stream_frame_o <= !fifo_out_data[FW-1];
                gap_cnt <= GAP_LAST[`ASS_GAP_W-1:0];
            end
        end
    end
endmodule

`default_nettype wire

// File: test/ass_seq_props.sv
/* Checker of the sequencer's port timing.
   Assumes the converter answers no sooner than two cycles. */
`timescale 1ns/100ps
`default_nettype none
module ass_seq_props (
    // Clock, reset and converter
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic conv_done_i,
    // Watched outputs
    input wire logic conv_start_o,
    input wire logic frame_start_o,
    input wire logic channel_step_o,
    input wire logic stream_valid_o,
    input wire logic stream_frame_o,
    input wire logic stream_src_o,
    input wire logic sequence_error_o,
    input wire logic overrun_o,
    input wire logic [10:0] stream_addr_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic [5:0] gap;
    logic eol_seen;
    logic [10:0] last_addr;
    wire own_word = stream_valid_o && !stream_src_o;
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            gap <= 6'h3f;
            eol_seen <= 1'b1;
            last_addr <= 11'h000;
        end else if (own_word) begin
            gap <= 6'h00;
            eol_seen <= !stream_frame_o;
            last_addr <= stream_addr_o;
        end else if (gap != 6'h3f) begin
            gap <= gap + 6'h01;
        end
    end
    frame_start_a: assert property (frame_start_o |-> conv_start_o)
        else $error("frame start without conversion");
    start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
        else $error("conversion start too long");
    step_pulse_a: assert property (channel_step_o |=> !channel_step_o)
        else $error("channel step too long");
    step_cause_a: assert property (channel_step_o |-> $past(conv_done_i))
        else $error("channel step without result");
    step_answer_a: assert property (conv_start_o ##2 conv_done_i |=> channel_step_o)
        else $error("result not followed by step");
    seq_sticky_a: assert property (sequence_error_o |=> sequence_error_o)
        else $error("order flag dropped");
    ovr_sticky_a: assert property (overrun_o |=> overrun_o)
        else $error("overrun flag dropped");
    word_gap_a: assert property (own_word |-> gap >= 6'd49)
        else $error("stream words too close");
    word_addr_a: assert property (own_word |->
        stream_addr_o == (eol_seen ? 11'h000 : last_addr + 11'h001))
        else $error("stream address out of sequence");
    cover property (own_word && !stream_frame_o);
    cover property (stream_valid_o && stream_src_o);
    cover property ($rose(sequence_error_o));
endmodule
bind ass_sequencer ass_seq_props u_props (.clock_i, .rst_i, .conv_done_i,
    .conv_start_o, .frame_start_o, .channel_step_o, .stream_valid_o,
    .stream_frame_o, .stream_src_o, .sequence_error_o, .overrun_o,
    .stream_addr_o);
`default_nettype wire

// File: test/ass_conv_model.sv
/* Converter and conditioning side: answers each start with a result,
   which carries its own scan index and the selected analog channel only for entries with the own bit set.
   Assumes the sequencer's pulse outputs. */
`timescale 1ns/100ps
`default_nettype none
module ass_conv_model (
    // Clock, reset, pace
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic slow_i,
    // From the sequencer
    input wire logic conv_start_i,
    input wire logic frame_start_i,
    input wire logic channel_step_i,
    input wire logic [1:0] bus_select_i,
    // Copy of the scan-table writes
    input wire logic tbl_we_i,
    input wire logic [10:0] tbl_waddr_i,
    input wire logic own_bit_i,
    // To the sequencer
    output logic conv_done_o,
    output logic [15:0] conv_data_o
);
    logic [10:0] idx;
    logic [2:0] wait_n;
    logic own_entry [0:2047];
    always @(posedge clock_i) begin
        if (tbl_we_i) begin
            own_entry[tbl_waddr_i] <= own_bit_i;
        end
    end
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            idx <= 11'h000;
            wait_n <= 3'h0;
            conv_done_o <= 1'b0;
            conv_data_o <= 16'h0000;
        end else begin
            conv_done_o <= 1'b0;
            // Released data never holds its last value
            conv_data_o <= ~conv_data_o;
            if (frame_start_i) begin
                idx <= 11'h000;
            end else if (channel_step_i) begin
                idx <= idx + 11'h001;
            end
            if (conv_start_i) begin
                wait_n <= slow_i ? 3'h5 : 3'h1;
            end else if (wait_n == 3'h1) begin
                conv_done_o <= 1'b1;
                if (own_entry[idx] === 1'b1) begin
                    conv_data_o <= {3'h5, idx, bus_select_i};
                end
                wait_n <= 3'h0;
            end else if (wait_n != 3'h0) begin
                wait_n <= wait_n - 3'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: test/tb.sv
/* Self-checking bench of the scan sequencer.
   Assumes the converter model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clock_i = 0, rst_i = 1, run_i = 0, sample_tick_i = 0;
    logic tbl_we_i = 0, ext_valid_i = 0, slow = 0;
    logic [10:0] tbl_waddr_i = 0;
    logic [15:0] tbl_wdata_i = 0, ext_data_i = 0;
    wire conv_done_i, conv_start_o, frame_start_o, channel_step_o;
    wire stream_valid_o, stream_frame_o, stream_src_o;
    wire sequence_error_o, overrun_o;
    wire [1:0] bus_select_o;
    wire [15:0] conv_data_i, stream_data_o;
    wire [10:0] stream_addr_o, scan_addr_o;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    logic [1:0] sel_exp [0:7];
    always #2 clock_i = ~clock_i;
    ass_sequencer DUT (.clock_i, .rst_i, .run_i, .sample_tick_i, .tbl_we_i,
        .tbl_waddr_i, .tbl_wdata_i, .conv_done_i, .conv_data_i,
        .conv_start_o, .bus_select_o, .frame_start_o, .channel_step_o,
        .stream_valid_o, .stream_data_o, .stream_addr_o, .stream_frame_o,
        .stream_src_o, .ext_valid_i, .ext_data_i, .scan_addr_o,
        .sequence_error_o, .overrun_o);
    ass_conv_model u_conv (.clock_i, .rst_i, .slow_i(slow),
        .conv_start_i(conv_start_o), .frame_start_i(frame_start_o),
        .channel_step_i(channel_step_o), .bus_select_i(bus_select_o),
        .tbl_we_i, .tbl_waddr_i, .own_bit_i(tbl_wdata_i[14]),
        .conv_done_o(conv_done_i), .conv_data_o(conv_data_i));
    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task put(input int a, input logic [15:0] d);
        @(posedge clock_i);
        tbl_we_i <= 1;
        tbl_waddr_i <= a[10:0];
        tbl_wdata_i <= d;
        sel_exp[a[2:0]] = d[1:0];
        @(posedge clock_i);
        tbl_we_i <= 0;
    endtask
    // Waits for one stream word, then holds off past the word gap
    // bench terminates the stream
    task get_word(input logic src, input logic [15:0] d, input int a,
                  input logic fr);
        int n;
        n = 0;
        do begin
            @(negedge clock_i);
            n++;
        end while (stream_valid_o !== 1'b1 && n < 200);
        check(stream_valid_o, 1'b1);
        check(stream_src_o, src);
        check(stream_data_o, d);
        if (!src) check(stream_addr_o, a[10:0]);
        if (!src) check(stream_frame_o, fr);
        repeat (60) @(posedge clock_i);
    endtask
    task scan_frame(input int nf);
        for (int f = 0; f < nf; f++) begin
            slow <= f[0];
            for (int i = 0; i < 6; i++) begin
                sample_tick_i <= 1;
                @(posedge clock_i);
                sample_tick_i <= 0;
                get_word(0, {3'h5, i[10:0], sel_exp[i]}, i, i != 5);
                check(scan_addr_o, 16'((i + 1) % 6));
                check(overrun_o, 0);
            end
        end
    endtask
    task ext_insert;
        @(posedge clock_i);
        ext_valid_i <= 1;
        ext_data_i <= 16'hbeef;
        @(posedge clock_i);
        ext_valid_i <= 0;
        get_word(1, 16'hbeef, 0, 0);
    endtask
    task bad_order;
        put(2, 16'h7fff);
        check(sequence_error_o, 0);
        scan_frame(1);
        check(sequence_error_o, 1);
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            print_verdict;
        end
    end
    initial begin
        repeat (10) @(posedge clock_i);
        rst_i <= 0;
        for (int i = 0; i < 6; i++) put(i, {i == 5, 13'h1fff, i[1:0]});
        @(posedge clock_i);
        run_i <= 1;
        @(posedge clock_i);
        scan_frame(2);
        ext_insert;
        bad_order;
        print_verdict;
    end
endmodule
`default_nettype wire
